// [testbench.sv]
// Self-checking bench for the temperature sensor serial slave port.
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sda_m, scl, sda_bus, sda_o, sda_oe, rv, alert, tm, hs;
  logic f_lvl, f_evt, f_abv;
  logic [1:0] pin_lo, pin_hi;
  logic [11:0] temp;
  logic [6:0] sa, ea;
  logic [7:0] rd, cfg;
  logic [15:0] tlow, thigh, v;
  logic [7:0] exp_q[$];
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  logic [31:0] seed = 32'h00001126;
  always #10 clk = ~clk;
  // Open-drain data wire with pull-up.
  assign sda_bus = sda_m & (~sda_oe | sda_o);
  tsp_slave_port uut (.clk(clk), .rst(rst), .scl_pin(scl), .sda_pin_i(sda_bus),
    .sda_pin_o(sda_o), .sda_pin_oe(sda_oe), .addr_select_pin_lo(pin_lo),
    .addr_select_pin_hi(pin_hi), .temp_word(temp), .fault_level(f_lvl), .fault_event(f_evt),
    .fault_above(f_abv), .alert(alert), .thermostat_irq_mode(tm), .hs_mode(hs),
    .slave_addr(sa), .cfg_byte(cfg), .tlow_word(tlow), .thigh_word(thigh));
  tsp_bus_master mdl (.clk(clk), .sda_i(sda_bus), .scl(scl), .sda_o(sda_m), .res_valid(rv),
    .res_data(rd));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wb(input logic [7:0] b, input logic a);
    exp_q.push_back({7'h00, a});
    mdl.xfer(b, 1'b0, 1'b0);
  endtask
  task automatic rb(input logic [7:0] e, input logic a, input logic [7:0] pull);
    exp_q.push_back(e);
    mdl.xfer(~pull, 1'b1, a);
  endtask
  task automatic wr_reg(input logic [7:0] p, input logic [15:0] d, input int n);
    mdl.cond(1'b1);
    wb({ea, 1'b0}, 1'b1);
    wb(p, 1'b1);
    if (n > 0) wb(d[15:8], 1'b1);
    if (n > 1) wb(d[7:0], 1'b1);
    mdl.cond(1'b0);
  endtask
  // Word read, optionally after a new pointer and a repeated start.
  task automatic rd_word(input logic [7:0] p, input logic set, input logic [15:0] e);
    mdl.cond(1'b1);
    if (set) begin
      wb({ea, 1'b0}, 1'b1);
      wb(p, 1'b1);
      mdl.cond(1'b1);
    end
    wb({ea, 1'b1}, 1'b1);
    rb(e[15:8], 1'b1, 8'h00);
    rb(e[7:0], 1'b0, 8'h00);
    mdl.cond(1'b0);
  endtask
  task automatic ara(input logic a, input logic [7:0] e, input logic [7:0] pull);
    mdl.cond(1'b1);
    wb(8'h19, a);
    if (a) rb(e, 1'b0, pull);
    mdl.cond(1'b0);
  endtask
  task automatic gcall(input logic [7:0] c);
    mdl.cond(1'b1);
    wb(8'h00, 1'b1);
    wb(c, 1'b1);
    mdl.cond(1'b0);
  endtask
  task automatic pulse(input logic above);
    f_abv = above;
    f_evt = 1'b1;
    mdl.wt(1);
    f_evt = 1'b0;
    mdl.wt(3);
  endtask
  // Each finished byte is judged against the oldest expectation.
  always @(posedge clk) begin
    if (rv === 1'b1) chk({8'h00, rd}, {8'h00, exp_q.pop_front()});
  end
  // Hang guard: the whole sequence needs well under this many cycles.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  initial begin
    f_lvl = 1'b0;
    f_evt = 1'b0;
    f_abv = 1'b0;
    pin_lo = 2'(xs() % 32'h3);
    pin_hi = 2'(xs() % 32'h3);
    temp = 12'(xs());
    mdl.wt(4);
    rst = 1'b0;
    mdl.wt(10);
    ea = 7'h48 + 7'(pin_lo);
    chk(16'(sa), 16'(ea));
    mdl.cond(1'b1);
    wb({7'h4F, 1'b0}, 1'b0);
    mdl.cond(1'b0);
    v = 16'(xs());
    wr_reg(8'h03, v, 2);
    chk(thigh, v);
    rd_word(8'h03, 1'b1, v);
    rd_word(8'h00, 1'b0, v);
    rd_word(8'h02, 1'b1, tsp_pkg::RST_TLOW);
    v = 16'(xs());
    wr_reg(8'h02, v, 2);
    chk(tlow, v);
    rd_word(8'h00, 1'b1, {temp, 4'h0});
    f_lvl = 1'b1;
    mdl.wt(4);
    chk(16'(alert), 16'h0001);
    f_lvl = 1'b0;
    mdl.wt(4);
    chk(16'(alert), 16'h0000);
    ara(1'b0, 8'h00, 8'h00);
    wr_reg(8'h01, 16'h0200, 1);
    chk(16'(tm), 16'h0001);
    pulse(1'b1);
    ara(1'b1, {ea, 1'b1}, 8'h00);
    chk(16'(alert), 16'h0000);
    pulse(1'b0);
    ara(1'b1, 8'h7F, 8'h80);
    chk(16'(alert), 16'h0001);
    rd_word(8'h01, 1'b0, 16'h0200);
    chk(16'(alert), 16'h0000);
    pin_lo = 2'((pin_lo + 2'h1) % 2'h3);
    gcall(8'h04);
    ea = 7'h48 + 7'(pin_lo);
    chk(16'(sa), 16'(ea));
    chk(16'(cfg), 16'h0002);
    pulse(1'b1);
    gcall(8'h06);
    chk(16'(alert), 16'h0000);
    chk(16'(tm), 16'h0000);
    chk(thigh, tsp_pkg::RST_THIGH);
    chk(tlow, tsp_pkg::RST_TLOW);
    mdl.cond(1'b1);
    wb(8'h08 | 8'(xs() & 32'h7), 1'b0);
    chk(16'(hs), 16'h0001);
    mdl.cond(1'b1);
    wb({ea, 1'b0}, 1'b1);
    chk(16'(hs), 16'h0001);
    mdl.cond(1'b0);
    chk(16'(hs), 16'h0000);
    chk(16'(exp_q.size()), 16'h0000);
    report_and_stop();
  end
endmodule

// [tsp_bus_master.sv]
// Behavioural bus master that drives the clock and data lines of the port.
`timescale 1ns/100ps
module tsp_bus_master (
  input wire logic clk,
  input wire logic sda_i,
  output logic scl,
  output logic sda_o,
  output logic res_valid,
  output logic [7:0] res_data
);
  // Idle bus: clock stands high, data left to the pull-up.
  initial begin
    scl = 1'b1;
    sda_o = 1'b1;
    res_valid = 1'b0;
    res_data = 8'h00;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Data moves one cycle after the clock falls so no synchroniser sees both at once.
  task automatic bit_x(input logic b, output logic s);
    wt(1);
    sda_o = b;
    wt(3);
    scl = 1'b1;
    wt(2);
    s = sda_i;
    wt(2);
    scl = 1'b0;
  endtask
  // Start (st=1, also repeated) or stop (st=0): data edge while clock high.
  task automatic cond(input logic st);
    wt(1);
    sda_o = st;
    wt(3);
    scl = 1'b1;
    wt(4);
    sda_o = ~st;
    wt(4);
    if (st) scl = 1'b0;
  endtask
  // One byte; in read mode drv is our inverted pull mask and ack answers the byte.
  task automatic xfer(input logic [7:0] drv, input logic rdm, input logic ack);
    logic [7:0] d;
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(drv[i], d[i]);
    end
    bit_x(rdm ? ~ack : 1'b1, s);
    res_data = rdm ? d : {7'h00, ~s};
    res_valid = 1'b1;
    wt(1);
    res_valid = 1'b0;
  endtask
endmodule

// [tsp_pkg.sv]
// Constants and types shared by the temperature sensor serial slave port.
package tsp_pkg;

  // Encoding of a sampled tri-level address select pin.
  localparam logic [1:0] PIN_LOW = 2'h0;
  localparam logic [1:0] PIN_FLOAT = 2'h1;
  localparam logic [1:0] PIN_HIGH = 2'h2;

  // Slave addresses of the single-pin variant.
  localparam logic [6:0] ADDR_1P_LOW = 7'h48;
  localparam logic [6:0] ADDR_1P_FLOAT = 7'h49;
  localparam logic [6:0] ADDR_1P_HIGH = 7'h4A;

  // Slave addresses of the two-pin variant, named by upper then lower pin.
  localparam logic [6:0] ADDR_2P_LL = 7'h48;
  localparam logic [6:0] ADDR_2P_LF = 7'h49;
  localparam logic [6:0] ADDR_2P_LH = 7'h4A;
  localparam logic [6:0] ADDR_2P_FL = 7'h4B;
  localparam logic [6:0] ADDR_2P_HL = 7'h4C;
  localparam logic [6:0] ADDR_2P_HF = 7'h4D;
  localparam logic [6:0] ADDR_2P_HH = 7'h4E;
  localparam logic [6:0] ADDR_2P_FH = 7'h4F;
  localparam logic [6:0] ADDR_2P_FF = 7'h48;

  // Special bus bytes.
  localparam logic [7:0] ALERT_RESP_BYTE = 8'h19;
  localparam logic [7:0] GEN_CALL_BYTE = 8'h00;
  localparam logic [7:0] GC_CMD_LATCH = 8'h04;
  localparam logic [7:0] GC_CMD_RESET = 8'h06;
  localparam logic [4:0] HS_CODE_TOP = 5'h01;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Register selection by the low pointer bits.
  localparam logic [1:0] PTR_TEMP = 2'h0;
  localparam logic [1:0] PTR_CFG = 2'h1;
  localparam logic [1:0] PTR_TLOW = 2'h2;
  localparam logic [1:0] PTR_THIGH = 2'h3;

  // Values after reset.
  localparam logic [7:0] RST_PTR = 8'h00;
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam logic [15:0] RST_TLOW = 16'h4B00;
  localparam logic [15:0] RST_THIGH = 16'h5000;
  localparam int CFG_TM_BIT = 1;

  // Cycles after reset before the address pins are caught.
  localparam logic [1:0] LATCH_DELAY = 2'h3;
  localparam logic [1:0] LATCH_NOW = 2'h1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX = 3'h1,
    ST_ACK_OUT = 3'h2,
    ST_TX = 3'h3,
    ST_ACK_IN = 3'h4
  } tsp_state_t;

  typedef enum logic [2:0] {
    PH_ADDR = 3'h0,
    PH_PTR = 3'h1,
    PH_DATA = 3'h2,
    PH_GC = 3'h3,
    PH_READ = 3'h4,
    PH_ARA = 3'h5
  } tsp_phase_t;

endpackage

// [tsp_regfile.sv]
// Register store of the sensor: configuration and limits, with registered read word.
`timescale 1ns/100ps
module tsp_regfile (
  input wire logic clk,
  input wire logic rst,
  input wire logic [11:0] temp_word,
  tsp_rf_if.store rf
);

  typedef struct packed {
    logic [7:0] cfg;
    logic [15:0] tlow;
    logic [15:0] thigh;
    logic [15:0] rd;
  } tsp_rf_state_t;

  tsp_rf_state_t q;
  tsp_rf_state_t d;

  // Byte writes land in the selected register; the read word follows one cycle later.
  always_comb begin
    d = q;
    if (rf.wr_en) begin
      case (rf.sel)
        tsp_pkg::PTR_CFG: begin
          if (rf.wr_hi) begin
            d.cfg = rf.wr_data;
          end
        end
        tsp_pkg::PTR_TLOW: begin
          if (rf.wr_hi) begin
            d.tlow[15:8] = rf.wr_data;
          end else begin
            d.tlow[7:0] = rf.wr_data;
          end
        end
        tsp_pkg::PTR_THIGH: begin
          if (rf.wr_hi) begin
            d.thigh[15:8] = rf.wr_data;
          end else begin
            d.thigh[7:0] = rf.wr_data;
          end
        end
        default: begin
          d.cfg = q.cfg; // The temperature word cannot be written.
        end
      endcase
    end
    case (rf.sel)
      tsp_pkg::PTR_TEMP: d.rd = {temp_word, 4'h0};
      tsp_pkg::PTR_CFG: d.rd = {q.cfg, 8'h00};
      tsp_pkg::PTR_TLOW: d.rd = q.tlow;
      default: d.rd = q.thigh;
    endcase
  end

  // A general call reset clears the store exactly like the pin reset.
  always_ff @(posedge clk) begin
    if (rst || rf.soft_rst) begin
      q.cfg <= tsp_pkg::RST_CFG;
      q.tlow <= tsp_pkg::RST_TLOW;
      q.thigh <= tsp_pkg::RST_THIGH;
      q.rd <= 16'h0000;
    end else begin
      q <= d;
    end
  end

  assign rf.rd_data = q.rd;
  assign rf.cfg = q.cfg;
  assign rf.tlow = q.tlow;
  assign rf.thigh = q.thigh;

endmodule

// [tsp_rf_if.sv]
// Carrier between the bus engine and its register store.
`timescale 1ns/100ps
interface tsp_rf_if;
  logic wr_en;
  logic wr_hi;
  logic [7:0] wr_data;
  logic [1:0] sel;
  logic soft_rst;
  logic [15:0] rd_data;
  logic [7:0] cfg;
  logic [15:0] tlow;
  logic [15:0] thigh;

  modport ctrl (
    output wr_en, wr_hi, wr_data, sel, soft_rst,
    input rd_data, cfg, tlow, thigh
  );
  modport store (
    input wr_en, wr_hi, wr_data, sel, soft_rst,
    output rd_data, cfg, tlow, thigh
  );
endinterface

// [tsp_slave_port.sv]
// Serial slave port of a temperature sensor: addressing, pointer, word reads, alert, call.
`timescale 1ns/100ps
module tsp_slave_port #(
  parameter logic TWO_PIN_VARIANT = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_pin,
  input wire logic sda_pin_i,
  output logic sda_pin_o,
  output logic sda_pin_oe,
  input wire logic [1:0] addr_select_pin_lo,
  input wire logic [1:0] addr_select_pin_hi,
  input wire logic [11:0] temp_word,
  input wire logic fault_level,
  input wire logic fault_event,
  input wire logic fault_above,
  output logic alert,
  output logic thermostat_irq_mode,
  output logic hs_mode,
  output logic [6:0] slave_addr,
  output logic [7:0] cfg_byte,
  output logic [15:0] tlow_word,
  output logic [15:0] thigh_word
);

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_s3;
    logic sda_s1;
    logic sda_s2;
    logic sda_s3;
    logic [1:0] alo_s1;
    logic [1:0] alo_s2;
    logic [1:0] ahi_s1;
    logic [1:0] ahi_s2;
    logic [1:0] latch_cnt;
    logic [6:0] addr;
    tsp_pkg::tsp_state_t st;
    tsp_pkg::tsp_phase_t ph;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic wr_hi;
    logic tx_hi;
    logic sda_oe;
    logic hs;
    logic alert;
    logic above;
    logic gc_done;
  } tsp_port_state_t;

  tsp_port_state_t q;
  tsp_port_state_t d;
  tsp_rf_if rf ();

  logic scl_rise;
  logic scl_fall;
  logic scl_high;
  logic start_det;
  logic stop_det;
  logic ara_ok;
  logic [7:0] next_tx;
  logic wr_en_c;
  logic gc_rst_c;
  logic read_done_c;
  logic ara_win_c;

  // Tri-level pin pair to slave address.
  function automatic logic [6:0] map_addr(input logic two, input logic [1:0] hi,
                                          input logic [1:0] lo);
    logic [6:0] a;
    a = tsp_pkg::ADDR_1P_LOW;
    if (!two) begin
      case (lo)
        tsp_pkg::PIN_FLOAT: a = tsp_pkg::ADDR_1P_FLOAT;
        tsp_pkg::PIN_HIGH: a = tsp_pkg::ADDR_1P_HIGH;
        default: a = tsp_pkg::ADDR_1P_LOW;
      endcase
    end else begin
      case ({hi, lo})
        {tsp_pkg::PIN_LOW, tsp_pkg::PIN_LOW}: a = tsp_pkg::ADDR_2P_LL;
        {tsp_pkg::PIN_LOW, tsp_pkg::PIN_FLOAT}: a = tsp_pkg::ADDR_2P_LF;
        {tsp_pkg::PIN_LOW, tsp_pkg::PIN_HIGH}: a = tsp_pkg::ADDR_2P_LH;
        {tsp_pkg::PIN_FLOAT, tsp_pkg::PIN_LOW}: a = tsp_pkg::ADDR_2P_FL;
        {tsp_pkg::PIN_HIGH, tsp_pkg::PIN_LOW}: a = tsp_pkg::ADDR_2P_HL;
        {tsp_pkg::PIN_HIGH, tsp_pkg::PIN_FLOAT}: a = tsp_pkg::ADDR_2P_HF;
        {tsp_pkg::PIN_HIGH, tsp_pkg::PIN_HIGH}: a = tsp_pkg::ADDR_2P_HH;
        {tsp_pkg::PIN_FLOAT, tsp_pkg::PIN_HIGH}: a = tsp_pkg::ADDR_2P_FH;
        default: a = tsp_pkg::ADDR_2P_FF;
      endcase
    end
    return a;
  endfunction

  // Bus events are seen on the synchronised copies only; s3 is the previous sample.
  assign scl_rise = q.scl_s2 && !q.scl_s3;
  assign scl_fall = !q.scl_s2 && q.scl_s3;
  assign scl_high = q.scl_s2 && q.scl_s3;
  assign start_det = scl_high && !q.sda_s2 && q.sda_s3;
  assign stop_det = scl_high && q.sda_s2 && !q.sda_s3;

  // The two-pin variant only answers the alert query in interrupt mode.
  assign ara_ok = q.alert && (!TWO_PIN_VARIANT || rf.cfg[tsp_pkg::CFG_TM_BIT]);
  assign next_tx = q.tx_hi ? rf.rd_data[15:8] : rf.rd_data[7:0];

  // Whole bus engine; one copy of the state is built here and registered below.
  always_comb begin
    d = q;
    wr_en_c = 1'b0;
    gc_rst_c = 1'b0;
    read_done_c = 1'b0;
    ara_win_c = 1'b0;
    d.scl_s1 = scl_pin;
    d.scl_s2 = q.scl_s1;
    d.scl_s3 = q.scl_s2;
    d.sda_s1 = sda_pin_i;
    d.sda_s2 = q.sda_s1;
    d.sda_s3 = q.sda_s2;
    d.alo_s1 = addr_select_pin_lo;
    d.alo_s2 = q.alo_s1;
    d.ahi_s1 = addr_select_pin_hi;
    d.ahi_s2 = q.ahi_s1;

    // The pins are read after reset and on a general call latch or reset command; otherwise only the latched address is used.
    if (q.latch_cnt != 2'h0) begin
      d.latch_cnt = q.latch_cnt - 2'h1;
      if (q.latch_cnt == tsp_pkg::LATCH_NOW) begin
        d.addr = map_addr(TWO_PIN_VARIANT, q.ahi_s2, q.alo_s2);
      end
    end

    if (stop_det) begin
      d.st = tsp_pkg::ST_IDLE;
      d.sda_oe = 1'b0;
      d.hs = 1'b0;
    end else if (start_det) begin
      // A repeated start keeps high-speed mode and drops any transfer in flight.
      d.st = tsp_pkg::ST_RX;
      d.ph = tsp_pkg::PH_ADDR;
      d.gc_done = 1'b0;
      d.cnt = 4'h0;
      d.sda_oe = 1'b0;
    end else begin
      case (q.st)
        tsp_pkg::ST_IDLE: d.st = tsp_pkg::ST_IDLE;
        tsp_pkg::ST_RX: begin
          if (scl_rise) begin
            d.sh = {q.sh[6:0], q.sda_s2};
            d.cnt = q.cnt + 4'h1;
          end else if (scl_fall && q.cnt == tsp_pkg::BITS_PER_BYTE) begin
            d.st = tsp_pkg::ST_ACK_OUT;
            d.sda_oe = 1'b1;
            case (q.ph)
              tsp_pkg::PH_ADDR: begin
                if (q.sh[7:3] == tsp_pkg::HS_CODE_TOP) begin
                  d.hs = 1'b1;
                  d.sda_oe = 1'b0;
                  d.st = tsp_pkg::ST_IDLE;
                end else if (q.sh == tsp_pkg::ALERT_RESP_BYTE && ara_ok) begin
                  d.ph = tsp_pkg::PH_ARA;
                end else if (q.sh[7:1] == q.addr) begin
                  d.ph = q.sh[0] ? tsp_pkg::PH_READ : tsp_pkg::PH_PTR;
                end else if (q.sh == tsp_pkg::GEN_CALL_BYTE) begin
                  d.ph = tsp_pkg::PH_GC;
                end else begin
                  d.sda_oe = 1'b0;
                  d.st = tsp_pkg::ST_IDLE;
                end
              end
              tsp_pkg::PH_PTR: begin
                d.ptr = q.sh;
                d.wr_hi = 1'b1;
                d.ph = tsp_pkg::PH_DATA;
              end
              tsp_pkg::PH_DATA: begin
                wr_en_c = 1'b1;
                d.wr_hi = !q.wr_hi;
              end
              tsp_pkg::PH_GC: begin
                d.gc_done = 1'b1;
                if (q.sh == tsp_pkg::GC_CMD_LATCH || q.sh == tsp_pkg::GC_CMD_RESET) begin
                  d.latch_cnt = tsp_pkg::LATCH_NOW;
                end
                if (q.sh == tsp_pkg::GC_CMD_RESET) begin
                  gc_rst_c = 1'b1;
                  d.ptr = tsp_pkg::RST_PTR;
                end
              end
              default: begin
                d.st = tsp_pkg::ST_IDLE;
              end
            endcase
          end
        end
        tsp_pkg::ST_ACK_OUT: begin
          if (scl_fall) begin
            d.sda_oe = 1'b0;
            d.cnt = 4'h0;
            case (q.ph)
              tsp_pkg::PH_READ: begin
                d.sh = rf.rd_data[15:8];
                d.sda_oe = !rf.rd_data[15];
                d.tx_hi = 1'b0;
                d.st = tsp_pkg::ST_TX;
              end
              tsp_pkg::PH_ARA: begin
                d.sh = {q.addr, q.above};
                d.sda_oe = !q.addr[6];
                d.st = tsp_pkg::ST_TX;
              end
              tsp_pkg::PH_GC: d.st = q.gc_done ? tsp_pkg::ST_IDLE : tsp_pkg::ST_RX;
              default: begin
                d.st = tsp_pkg::ST_RX;
              end
            endcase
          end
        end
        tsp_pkg::ST_TX: begin
          if (scl_rise) begin
            d.cnt = q.cnt + 4'h1;
            // Sending a one while the line reads zero means another device won.
            if (q.ph == tsp_pkg::PH_ARA && !q.sda_oe && !q.sda_s2) begin
              d.st = tsp_pkg::ST_IDLE;
            end
          end else if (scl_fall) begin
            if (q.cnt == tsp_pkg::BITS_PER_BYTE) begin
              d.sda_oe = 1'b0;
              d.st = tsp_pkg::ST_ACK_IN;
              ara_win_c = (q.ph == tsp_pkg::PH_ARA);
            end else begin
              d.sh = {q.sh[6:0], 1'b0};
              d.sda_oe = !q.sh[6];
            end
          end
        end
        tsp_pkg::ST_ACK_IN: begin
          if (scl_rise) begin
            read_done_c = (q.ph == tsp_pkg::PH_READ);
            if (q.sda_s2 || q.ph == tsp_pkg::PH_ARA) begin
              d.st = tsp_pkg::ST_IDLE;
            end
          end else if (scl_fall) begin
            d.sh = next_tx;
            d.sda_oe = !next_tx[7];
            d.tx_hi = !q.tx_hi;
            d.cnt = 4'h0;
            d.st = tsp_pkg::ST_TX;
          end
        end
        default: begin
          d.st = tsp_pkg::ST_IDLE;
          d.sda_oe = 1'b0;
        end
      endcase
    end

    // Alert: a level in comparator mode, sticky in interrupt mode; a new event wins.
    if (rf.cfg[tsp_pkg::CFG_TM_BIT]) begin
      if (read_done_c || ara_win_c || gc_rst_c) begin
        d.alert = 1'b0;
      end
      if (fault_event) begin
        d.alert = 1'b1;
        d.above = fault_above;
      end
    end else begin
      d.alert = fault_level && !gc_rst_c;
      d.above = fault_above;
    end
  end

  // Synchronous reset; the address latch is armed so the pins are caught after release.
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.scl_s1 <= 1'b1;
      q.scl_s2 <= 1'b1;
      q.scl_s3 <= 1'b1;
      q.sda_s1 <= 1'b1;
      q.sda_s2 <= 1'b1;
      q.sda_s3 <= 1'b1;
      q.ptr <= tsp_pkg::RST_PTR;
      q.latch_cnt <= tsp_pkg::LATCH_DELAY;
    end else begin
      q <= d;
    end
  end

  // Register store, pointer low bits select the word.
  assign rf.wr_en = wr_en_c;
  assign rf.wr_hi = q.wr_hi;
  assign rf.wr_data = q.sh;
  assign rf.sel = q.ptr[1:0];
  assign rf.soft_rst = gc_rst_c;

  tsp_regfile u_regfile (
    .clk(clk),
    .rst(rst),
    .temp_word(temp_word),
    .rf(rf)
  );

  // Open drain: the line is only ever pulled low.
  assign sda_pin_o = 1'b0;
  assign sda_pin_oe = q.sda_oe;
  assign alert = q.alert;
  assign thermostat_irq_mode = rf.cfg[tsp_pkg::CFG_TM_BIT];
  assign hs_mode = q.hs;
  assign slave_addr = q.addr;
  assign cfg_byte = rf.cfg;
  assign tlow_word = rf.tlow;
  assign thigh_word = rf.thigh;

endmodule

// [tsp_slave_port_chk.sv]
// Concurrent checks on the pins and status outputs of the slave port.
`timescale 1ns/100ps
module tsp_slave_port_chk #(
  parameter logic TWO_PIN_VARIANT = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_pin,
  input wire logic sda_pin_i,
  input wire logic sda_pin_o,
  input wire logic sda_pin_oe,
  input wire logic [1:0] addr_select_pin_lo,
  input wire logic fault_level,
  input wire logic fault_event,
  input wire logic alert,
  input wire logic thermostat_irq_mode,
  input wire logic hs_mode,
  input wire logic [6:0] slave_addr,
  input wire logic [7:0] cfg_byte
);
  logic sda_q;
  logic [7:0] stop_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Recent stops on the raw pins; high-speed mode may only end just after one.
  always_ff @(posedge clk) begin
    sda_q <= sda_pin_i;
    stop_q <= {stop_q[6:0], scl_pin & sda_pin_i & ~sda_q};
  end
  sequence s_start;
    scl_pin && $fell(sda_pin_i);
  endsequence
  sequence s_stop;
    scl_pin && $rose(sda_pin_i);
  endsequence
  a_open_drain: assert property (
    sda_pin_o == 1'b0) else $error("data output not low");
  a_oe_scl_low: assert property (
    $changed(sda_pin_oe) |-> !$past(scl_pin) || $stable(sda_pin_i))
    else $error("data wire moved by device with clock high");
  a_start_release: assert property (
    s_start |-> (!sda_pin_oe) [*8]) else $error("data driven after start");
  a_stop_hs_clear: assert property (
    s_stop |-> ##[1:8] !hs_mode) else $error("high-speed kept after stop");
  a_hs_only_stop: assert property (
    $fell(hs_mode) |-> stop_q != 8'h00) else $error("high-speed left without stop");
  a_alert_follow: assert property (
    (!thermostat_irq_mode && $stable(fault_level)) [*3] |-> alert == fault_level)
    else $error("comparator alert wrong");
  a_event_alert: assert property (
    thermostat_irq_mode && fault_event |-> ##[1:2] alert) else $error("alert not set");
  a_addr_latch: assert property (
    $fell(rst) |-> ##[4:6] (TWO_PIN_VARIANT || slave_addr == 7'h48 + 7'(addr_select_pin_lo)))
    else $error("address not latched");
  a_addr_range: assert property (
    slave_addr == 7'h00 || (slave_addr[6:3] == 4'h9
    && (TWO_PIN_VARIANT || slave_addr[2:0] < 3'h3))) else $error("address out of range");
  a_tm_mirror: assert property (
    thermostat_irq_mode == cfg_byte[tsp_pkg::CFG_TM_BIT]) else $error("mode bit mismatch");
endmodule
bind tsp_slave_port tsp_slave_port_chk #(.TWO_PIN_VARIANT(TWO_PIN_VARIANT)) chk_i (
  .clk(clk), .rst(rst), .scl_pin(scl_pin), .sda_pin_i(sda_pin_i), .sda_pin_o(sda_pin_o),
  .sda_pin_oe(sda_pin_oe), .addr_select_pin_lo(addr_select_pin_lo),
  .fault_level(fault_level), .fault_event(fault_event), .alert(alert),
  .thermostat_irq_mode(thermostat_irq_mode), .hs_mode(hs_mode), .slave_addr(slave_addr),
  .cfg_byte(cfg_byte));
